// ==== shared/phy_mgmt_pkg.sv ====
// Purpose: Shared constants and carriers for the PHY management registers.
// Assumes: Registers are 16 bits wide on a five-bit management address.
// Notes: Field positions are bit indices inside the 16-bit words.
package phy_mgmt_pkg;

    // Register addresses on the management bus.
    localparam logic [4:0] ADDR_EXT_CTRL = 5'h11;
    localparam logic [4:0] ADDR_CFG_ONE = 5'h12;

    // Extended control field positions.
    localparam int EC_LINK = 15;
    localparam int EC_MODE_LO = 11;
    localparam int EC_JITTER = 10;
    localparam int EC_RESTART = 9;
    localparam int EC_TEST_LO = 6;
    localparam int EC_CABLE = 5;
    localparam int EC_LOOP_LO = 3;
    localparam int EC_CFG_EN = 2;
    localparam int EC_SUPPLY = 1;
    localparam int EC_WAKE = 0;

    // Configuration one field positions.
    localparam int C1_ROLE = 15;
    localparam int C1_AUTO = 14;
    localparam int C1_LENGTH = 13;
    localparam int C1_SPARE = 12;
    localparam int C1_AMP_LO = 10;
    localparam int C1_MII_LO = 8;
    localparam int C1_DRIVER = 7;
    localparam int C1_LED_LO = 4;
    localparam int C1_LED_EN = 3;
    localparam int C1_WTHR = 2;
    localparam int C1_PWD = 1;

    // Operating mode request codes.
    localparam logic [3:0] MODE_NOCHANGE = 4'h0;
    localparam logic [3:0] MODE_NORMAL = 4'h3;
    localparam logic [3:0] MODE_STANDBY = 4'hC;
    localparam logic [3:0] MODE_SLEEPREQ = 4'hB;

    // Test pattern code that is never stored.
    localparam logic [2:0] TEST_RESERVED = 3'h7;

    // Indicator source codes.
    localparam logic [1:0] LED_LINK = 2'h0;
    localparam logic [1:0] LED_RX = 2'h1;
    localparam logic [1:0] LED_SYMERR = 2'h2;
    localparam logic [1:0] LED_CRS = 2'h3;

    // Positions of the synchronised pin inputs.
    localparam int SY_ROLE = 0;
    localparam int SY_AUTO = 1;
    localparam int SY_MII_LO = 2;
    localparam int SY_LINK = 4;
    localparam int SY_RX = 5;
    localparam int SY_SERR = 6;
    localparam int SY_CRS = 7;
    localparam int SY_PIN = 8;
    localparam int SYNC_W = 9;

    // Strap capture phases, Gray coded.
    typedef enum logic [1:0] {
        SP_WAIT0 = 2'b00,
        SP_WAIT1 = 2'b01,
        SP_WAIT2 = 2'b11,
        SP_RUN = 2'b10
    } strap_phase_e;

    // Management request and answer.
    typedef struct packed {
        logic valid;
        logic write;
        logic [4:0] addr;
        logic [15:0] wdata;
    } mgmt_req_s;

    typedef struct packed {
        logic valid;
        logic [15:0] rdata;
    } mgmt_rsp_s;

    // Stored control and configuration fields.
    typedef struct packed {
        logic link_enable;
        logic [3:0] mode_request;
        logic jitter_test_en;
        logic [2:0] test_mode;
        logic [1:0] loopback_mode;
        logic config_access_en;
        logic supply_output_policy;
        logic wake_request_tx;
        logic master_role;
        logic autonomous_operation;
        logic link_length;
        logic cfg_spare;
        logic [1:0] tx_amplitude;
        logic [1:0] iface_mode;
        logic driver_reduced;
        logic [1:0] indicator_source_select;
        logic indicator_pin_enable;
        logic wake_threshold_ratio;
        logic auto_power_down;
    } phy_ctrl_s;

    // Reset values of the stored fields.
    localparam phy_ctrl_s CTRL_RST = '{
        supply_output_policy: 1'b1,
        tx_amplitude: 2'h2,
        indicator_source_select: 2'h1,
        default: '0
    };

endpackage : phy_mgmt_pkg

// ==== hw/pin_sync.sv ====
// Purpose: Two-stage synchroniser for a bundle of pin inputs.
// Assumes: Each bit is an independent level; no bus coherence is implied.
// Notes: The first stage feeds only the second stage.
module pin_sync #(
    parameter int WIDTH = 9
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] pins,
    output logic [WIDTH-1:0] synced
);

    // First stage; metastability settles here.
    logic [WIDTH-1:0] meta_r;

    // Both stages freeze with the clock enable like all other state.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            synced <= '0;
        end else if (ce) begin
            meta_r <= pins;
            synced <= meta_r;
        end
    end

endmodule : pin_sync

// ==== hw/phy_ext_control_config_regs.sv ====
// Purpose: Extended control and first configuration registers of the PHY.
// Assumes: Pins and straps are asynchronous; mode inputs share sys_clk.
// Notes: Requests are refused until the straps have been captured.
// Functional notes
// - Link enable resets to autonomous strap value.
// - Illegal operating mode code raises control error.
// - Bit 10 enables slave jitter test.
// - Bit 9 restarts training, self clears.
// - Test field selects patterns; 111 reserved.
// - Bit 5 starts cable test, self clears.
// - Bit 2 gates configuration register writes.
// - Bit 1 keeps supply output in Disable.
// - Bit 0 sends idle wake-up request.
// - Configuration bit 15 selects master role.
// - Interface field selects MII, RMII or reverse.
// - Bit 7 selects reduced driver strength.
// - Bits 5:4 choose indicator source.
// - Bit 3 shares pin: indicator or wake.
// - Role, autonomous, interface reset from straps.
// - Wake input active in low power modes while bit 3 is clear.
// - Latched status defaults while link disabled.
module phy_ext_control_config_regs (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire phy_mgmt_pkg::mgmt_req_s mgmt_req,
    output phy_mgmt_pkg::mgmt_rsp_s mgmt_rsp,
    input wire logic strap_master,
    input wire logic strap_autonomous,
    input wire logic [1:0] strap_iface_mode,
    input wire logic link_up,
    input wire logic frame_receiving,
    input wire logic symbol_error,
    input wire logic carrier_sense,
    input wire logic shared_pin_i,
    input wire logic disable_mode,
    input wire logic low_power_mode,
    output phy_mgmt_pkg::phy_ctrl_s ctrl,
    output logic mode_strobe,
    output logic control_error,
    output logic training_restart,
    output logic cable_test_start,
    output logic supply_control_output,
    output logic shared_pin_o,
    output logic shared_pin_oe,
    output logic wake_input_en,
    output logic local_wake,
    output logic status_hold_default
);

    // Whole state of the block in one record.
    typedef struct packed {
        phy_mgmt_pkg::strap_phase_e phase;
        phy_mgmt_pkg::phy_ctrl_s ctrl;
        logic mode_strobe;
        logic control_error;
        logic training_restart;
        logic cable_test_start;
        logic supply_on;
        logic pin_o;
        logic pin_oe;
        logic wake_en;
        logic wake_seen;
        logic status_default;
        phy_mgmt_pkg::mgmt_rsp_s rsp;
    } state_s;

    localparam state_s STATE_RST = '{
        phase: phy_mgmt_pkg::SP_WAIT0,
        ctrl: phy_mgmt_pkg::CTRL_RST,
        supply_on: 1'b1,
        default: '0
    };

    state_s state_r;
    state_s state_nxt;
    logic [phy_mgmt_pkg::SYNC_W-1:0] pins_raw; // Asynchronous inputs.
    logic [phy_mgmt_pkg::SYNC_W-1:0] pins_s; // Their synchronised copies.
    logic wr_ext; // Write to the extended control register.
    logic wr_cfg; // Write to configuration one.

    // True when a live request targets the given address.
    function automatic logic hit(phy_mgmt_pkg::mgmt_req_s r,
                                 logic [4:0] a);
        return r.valid && (r.addr == a);
    endfunction : hit

    // True for the mode codes that the mode controller accepts.
    function automatic logic mode_legal(logic [3:0] m);
        return (m == phy_mgmt_pkg::MODE_NOCHANGE) ||
               (m == phy_mgmt_pkg::MODE_NORMAL) ||
               (m == phy_mgmt_pkg::MODE_STANDBY) ||
               (m == phy_mgmt_pkg::MODE_SLEEPREQ);
    endfunction : mode_legal

    assign pins_raw = {shared_pin_i, carrier_sense, symbol_error,
                       frame_receiving, link_up, strap_iface_mode,
                       strap_autonomous, strap_master};

    // Straps and status pins cross into sys_clk here.
    pin_sync #(
        .WIDTH(phy_mgmt_pkg::SYNC_W)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .pins(pins_raw),
        .synced(pins_s)
    );

    // Writes count only once straps are in.
    assign wr_ext = hit(mgmt_req, phy_mgmt_pkg::ADDR_EXT_CTRL) &&
                    mgmt_req.write && (state_r.phase == phy_mgmt_pkg::SP_RUN);
    assign wr_cfg = hit(mgmt_req, phy_mgmt_pkg::ADDR_CFG_ONE) &&
                    mgmt_req.write && (state_r.phase == phy_mgmt_pkg::SP_RUN);

    // Next-state logic for registers, pulses and pin-facing outputs.
    always_comb begin
        logic [15:0] w;
        logic [1:0] src;
        w = mgmt_req.wdata;
        src = state_r.ctrl.indicator_source_select;
        state_nxt = state_r;
        // Event outputs and self-clearing bits last one cycle only.
        state_nxt.mode_strobe = 1'b0;
        state_nxt.control_error = 1'b0;
        state_nxt.training_restart = 1'b0;
        state_nxt.cable_test_start = 1'b0;
        state_nxt.rsp.valid = 1'b0;
        case (state_r.phase)
            phy_mgmt_pkg::SP_WAIT0: begin
                state_nxt.phase = phy_mgmt_pkg::SP_WAIT1;
            end
            phy_mgmt_pkg::SP_WAIT1: begin
                state_nxt.phase = phy_mgmt_pkg::SP_WAIT2;
            end
            phy_mgmt_pkg::SP_WAIT2: begin
                // Synchroniser is full now, so the straps are valid.
                state_nxt.phase = phy_mgmt_pkg::SP_RUN;
                state_nxt.ctrl.master_role = pins_s[phy_mgmt_pkg::SY_ROLE];
                state_nxt.ctrl.autonomous_operation =
                    pins_s[phy_mgmt_pkg::SY_AUTO];
                state_nxt.ctrl.iface_mode =
                    pins_s[phy_mgmt_pkg::SY_MII_LO +: 2];
                state_nxt.ctrl.link_enable = pins_s[phy_mgmt_pkg::SY_AUTO];
            end
            default: begin
                state_nxt.phase = phy_mgmt_pkg::SP_RUN;
            end
        endcase
        if (wr_ext) begin
            state_nxt.ctrl.link_enable = w[phy_mgmt_pkg::EC_LINK];
            if (!mode_legal(w[phy_mgmt_pkg::EC_MODE_LO +: 4])) begin
                state_nxt.control_error = 1'b1;
            end else if (w[phy_mgmt_pkg::EC_MODE_LO +: 4] !=
                         phy_mgmt_pkg::MODE_NOCHANGE) begin
                // A no-change code leaves the last request in place.
                state_nxt.ctrl.mode_request =
                    w[phy_mgmt_pkg::EC_MODE_LO +: 4];
                state_nxt.mode_strobe = 1'b1;
            end
            state_nxt.ctrl.jitter_test_en = w[phy_mgmt_pkg::EC_JITTER];
            state_nxt.training_restart = w[phy_mgmt_pkg::EC_RESTART];
            // The reserved pattern would drive an undefined transmitter.
            if (w[phy_mgmt_pkg::EC_TEST_LO +: 3] !=
                phy_mgmt_pkg::TEST_RESERVED) begin
                state_nxt.ctrl.test_mode = w[phy_mgmt_pkg::EC_TEST_LO +: 3];
            end
            state_nxt.cable_test_start = w[phy_mgmt_pkg::EC_CABLE];
            state_nxt.ctrl.loopback_mode = w[phy_mgmt_pkg::EC_LOOP_LO +: 2];
            state_nxt.ctrl.config_access_en = w[phy_mgmt_pkg::EC_CFG_EN];
            state_nxt.ctrl.supply_output_policy = w[phy_mgmt_pkg::EC_SUPPLY];
            // Ordering against link enable is left to the station.
            state_nxt.ctrl.wake_request_tx = w[phy_mgmt_pkg::EC_WAKE];
        end
        if (wr_cfg && state_r.ctrl.config_access_en) begin
            state_nxt.ctrl.master_role = w[phy_mgmt_pkg::C1_ROLE];
            state_nxt.ctrl.autonomous_operation = w[phy_mgmt_pkg::C1_AUTO];
            state_nxt.ctrl.link_length = w[phy_mgmt_pkg::C1_LENGTH];
            state_nxt.ctrl.cfg_spare = w[phy_mgmt_pkg::C1_SPARE];
            state_nxt.ctrl.tx_amplitude = w[phy_mgmt_pkg::C1_AMP_LO +: 2];
            state_nxt.ctrl.iface_mode = w[phy_mgmt_pkg::C1_MII_LO +: 2];
            state_nxt.ctrl.driver_reduced = w[phy_mgmt_pkg::C1_DRIVER];
            state_nxt.ctrl.indicator_source_select =
                w[phy_mgmt_pkg::C1_LED_LO +: 2];
            state_nxt.ctrl.indicator_pin_enable = w[phy_mgmt_pkg::C1_LED_EN];
            state_nxt.ctrl.wake_threshold_ratio = w[phy_mgmt_pkg::C1_WTHR];
            state_nxt.ctrl.auto_power_down = w[phy_mgmt_pkg::C1_PWD];
            // Bits 6 and 0 are not stored and read as zero.
        end
        // Reads answer one cycle later; unmapped addresses read zero.
        if (mgmt_req.valid && !mgmt_req.write &&
            (state_r.phase == phy_mgmt_pkg::SP_RUN)) begin
            state_nxt.rsp.valid = 1'b1;
            state_nxt.rsp.rdata = 16'h0000;
            if (hit(mgmt_req, phy_mgmt_pkg::ADDR_EXT_CTRL)) begin
                state_nxt.rsp.rdata = {state_r.ctrl.link_enable,
                    state_r.ctrl.mode_request, state_r.ctrl.jitter_test_en,
                    state_r.training_restart, state_r.ctrl.test_mode,
                    state_r.cable_test_start, state_r.ctrl.loopback_mode,
                    state_r.ctrl.config_access_en,
                    state_r.ctrl.supply_output_policy,
                    state_r.ctrl.wake_request_tx};
            end else if (hit(mgmt_req, phy_mgmt_pkg::ADDR_CFG_ONE)) begin
                state_nxt.rsp.rdata = {state_r.ctrl.master_role,
                    state_r.ctrl.autonomous_operation,
                    state_r.ctrl.link_length, state_r.ctrl.cfg_spare,
                    state_r.ctrl.tx_amplitude, state_r.ctrl.iface_mode,
                    state_r.ctrl.driver_reduced, 1'b0,
                    state_r.ctrl.indicator_source_select,
                    state_r.ctrl.indicator_pin_enable,
                    state_r.ctrl.wake_threshold_ratio,
                    state_r.ctrl.auto_power_down, 1'b0};
            end
        end
        // Pin-facing outputs follow the stored fields one cycle later.
        state_nxt.supply_on = !disable_mode ||
                              state_r.ctrl.supply_output_policy;
        state_nxt.pin_oe = state_r.ctrl.indicator_pin_enable;
        case (src)
            phy_mgmt_pkg::LED_LINK: state_nxt.pin_o =
                pins_s[phy_mgmt_pkg::SY_LINK];
            phy_mgmt_pkg::LED_RX: state_nxt.pin_o = pins_s[phy_mgmt_pkg::SY_RX];
            phy_mgmt_pkg::LED_SYMERR: state_nxt.pin_o =
                pins_s[phy_mgmt_pkg::SY_SERR];
            default: state_nxt.pin_o = pins_s[phy_mgmt_pkg::SY_CRS];
        endcase
        state_nxt.pin_o = state_nxt.pin_o && state_r.ctrl.indicator_pin_enable;
        state_nxt.wake_en = low_power_mode &&
                            !state_r.ctrl.indicator_pin_enable;
        state_nxt.wake_seen = state_r.wake_en && pins_s[phy_mgmt_pkg::SY_PIN];
        state_nxt.status_default = !state_r.ctrl.link_enable;
    end

    // Single register stage; the clock enable freezes everything.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= STATE_RST;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    assign mgmt_rsp = state_r.rsp;
    assign ctrl = state_r.ctrl;
    assign mode_strobe = state_r.mode_strobe;
    assign control_error = state_r.control_error;
    assign training_restart = state_r.training_restart;
    assign cable_test_start = state_r.cable_test_start;
    assign supply_control_output = state_r.supply_on;
    assign shared_pin_o = state_r.pin_o;
    assign shared_pin_oe = state_r.pin_oe;
    assign wake_input_en = state_r.wake_en;
    assign local_wake = state_r.wake_seen;
    assign status_hold_default = state_r.status_default;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_LINK_STRAP: assert property (
        ce && state_r.phase == phy_mgmt_pkg::SP_WAIT2 |=>
        ctrl.link_enable == ctrl.autonomous_operation &&
        ctrl.autonomous_operation == $past(pins_s[phy_mgmt_pkg::SY_AUTO]))
        else $error("link enable did not follow the autonomous strap");
    AST_MODE_ERR: assert property (
        ce && wr_ext && !mode_legal(mgmt_req.wdata[14:11]) |=>
        control_error && !mode_strobe ##1 (!ce || !control_error ||
        $past(wr_ext)))
        else $error("illegal mode code did not raise a single error");
    AST_MODE_OK: assert property (
        ce && wr_ext && mode_legal(mgmt_req.wdata[14:11]) |=> !control_error)
        else $error("legal mode code raised an error");
    AST_RESTART_SC: assert property (
        ce && wr_ext && mgmt_req.wdata[9] ##1 ce && !wr_ext |=>
        !training_restart)
        else $error("training restart did not self clear");
    AST_TEST_RSV: assert property (
        ce && wr_ext && mgmt_req.wdata[8:6] == phy_mgmt_pkg::TEST_RESERVED
        |=> $stable(ctrl.test_mode))
        else $error("reserved test code was stored");
    AST_CFG_GATE: assert property (
        ce && wr_cfg && !ctrl.config_access_en |=>
        $stable(ctrl.tx_amplitude) && $stable(ctrl.master_role) &&
        $stable(ctrl.indicator_pin_enable))
        else $error("configuration write passed a closed gate");
    AST_SUPPLY: assert property (
        ce && disable_mode && !ctrl.supply_output_policy |=>
        !supply_control_output)
        else $error("supply output stayed on in Disable mode");
    AST_WAKE_EN: assert property (
        ce && ctrl.indicator_pin_enable |=> !wake_input_en && shared_pin_oe)
        else $error("wake input active while indicator owns the pin");
    AST_STATUS_DEF: assert property (
        ce && !ctrl.link_enable |=> status_hold_default)
        else $error("status default not held with link disabled");
    AST_CABLE: assert property (
        ce && wr_ext && mgmt_req.wdata[5] |=> cable_test_start)
        else $error("cable test start missing");

    COV_MODE_ERR: cover property (ce && wr_ext ##1 control_error);
    COV_RESTART: cover property (ce && wr_ext ##1 training_restart);
    COV_CFG_WRITE: cover property (ce && wr_cfg && ctrl.config_access_en);
    COV_WAKE: cover property (wake_input_en ##1 local_wake);

endmodule : phy_ext_control_config_regs

// ==== verification/mgmt_station.sv ====
// Purpose: Management station model issuing register reads and writes.
// Assumes: Callers wait until strap capture is done before the first call.
// Notes: Released request lines are scrambled, never left at old values.
module mgmt_station (
    input wire logic sys_clk,
    input wire phy_mgmt_pkg::mgmt_rsp_s mgmt_rsp,
    output phy_mgmt_pkg::mgmt_req_s mgmt_req
);
    timeunit 1ns;
    timeprecision 1ps;

    // The bus is idle until the first request.
    initial mgmt_req = '0;

    // A write is taken at the edge after it is raised; no answer comes.
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] w;
        // Reserved configuration bits are always written as zero.
        w = (a == phy_mgmt_pkg::ADDR_CFG_ONE) ? (d & 16'hFFBE) : d;
        @(posedge sys_clk);
        mgmt_req <= '{valid: 1'b1, write: 1'b1, addr: a, wdata: w};
        @(posedge sys_clk);
        mgmt_req <= '{valid: 1'b0, write: 1'b0, addr: ~a, wdata: ~w};
    endtask : wr

    // A read answers in the cycle after the taking edge, for one cycle.
    task automatic rd(input logic [4:0] a, output logic [15:0] d,
                      output logic v);
        @(posedge sys_clk);
        mgmt_req <= '{valid: 1'b1, write: 1'b0, addr: a, wdata: 16'h0000};
        @(posedge sys_clk);
        mgmt_req <= '{valid: 1'b0, write: 1'b1, addr: ~a, wdata: 16'hFFFF};
        #1;
        d = mgmt_rsp.rdata;
        v = mgmt_rsp.valid;
    endtask : rd
endmodule : mgmt_station

// ==== verification/tb_phy_ext_control_config_regs.sv ====
// Purpose: Self-checking bench for the control and configuration registers.
// Assumes: Straps start as master, autonomous, interface 01; a reset flips.
// Notes: Each status input has its own bit so the indicator mux is seen.
module tb_phy_ext_control_config_regs;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [4:0] EXT = phy_mgmt_pkg::ADDR_EXT_CTRL;
    localparam logic [4:0] CF1 = phy_mgmt_pkg::ADDR_CFG_ONE;

    logic sys_clk = 1'b0; // Free-running 50 MHz clock.
    logic rst_n = 1'b0; // Held low for the first twelve cycles.
    logic [3:0] status_in = 4'h0; // Link, frame, symbol error, carrier.
    logic strap_master = 1'b1; // Strap levels, changed before a reset.
    logic strap_autonomous = 1'b1;
    logic [1:0] strap_iface_mode = 2'h1;
    logic shared_pin_i = 1'b1; // Wake level seen on the shared pin.
    logic disable_mode = 1'b0;
    logic low_power_mode = 1'b0;
    phy_mgmt_pkg::mgmt_req_s mgmt_req;
    phy_mgmt_pkg::mgmt_rsp_s mgmt_rsp;
    phy_mgmt_pkg::phy_ctrl_s ctrl;
    logic mode_strobe, control_error, training_restart, cable_test_start;
    logic supply_control_output, shared_pin_o, shared_pin_oe;
    logic wake_input_en, local_wake, status_hold_default;
    int mismatches = 0;
    int num_checks = 0;

    // Half-period toggle gives the 20 ns clock.
    always #10 sys_clk = ~sys_clk;

    phy_ext_control_config_regs dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .ce(1'b1), .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp),
        .strap_master(strap_master),
        .strap_autonomous(strap_autonomous),
        .strap_iface_mode(strap_iface_mode), .link_up(status_in[0]),
        .frame_receiving(status_in[1]), .symbol_error(status_in[2]),
        .carrier_sense(status_in[3]), .shared_pin_i(shared_pin_i),
        .disable_mode(disable_mode), .low_power_mode(low_power_mode),
        .ctrl(ctrl), .mode_strobe(mode_strobe),
        .control_error(control_error), .training_restart(training_restart),
        .cable_test_start(cable_test_start),
        .supply_control_output(supply_control_output),
        .shared_pin_o(shared_pin_o), .shared_pin_oe(shared_pin_oe),
        .wake_input_en(wake_input_en), .local_wake(local_wake),
        .status_hold_default(status_hold_default));

    mgmt_station stn (.sys_clk(sys_clk), .mgmt_rsp(mgmt_rsp),
        .mgmt_req(mgmt_req));

    // Compares one value and reports a mismatch at once.
    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Reads a register and expects a valid answer with the given word.
    task automatic rc(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        stn.rd(a, d, v);
        chk("rsp_valid", 16'(v), 16'h0001);
        chk("rdata", d, exp);
    endtask : rc

    // Waits n edges, then lets that edge's updates land.
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : settle

    // Reset values depend on the straps; unmapped reads give zero.
    task automatic test_reset();
        rc(EXT, 16'h8002);
        rc(CF1, 16'hC910);
        rc(5'h05, 16'h0000);
        chk("supply", 16'(supply_control_output), 16'h0001);
        $display("test_reset done");
    endtask : test_reset

    // Every mode code once; only the three legal codes other than no-change are stored.
    task automatic test_modes();
        logic [3:0] m;
        logic [3:0] keep;
        logic legal;
        keep = 4'h0;
        for (int i = 0; i < 16; i++) begin
            m = 4'(i);
            legal = (m == phy_mgmt_pkg::MODE_NORMAL) ||
                (m == phy_mgmt_pkg::MODE_STANDBY) ||
                (m == phy_mgmt_pkg::MODE_SLEEPREQ);
            stn.wr(EXT, {1'b0, m, 11'h002});
            #1;
            chk("strobe", 16'(mode_strobe), 16'(legal));
            chk("error", 16'(control_error), 16'(!legal && m != 0));
            if (legal) keep = m;
            chk("mode", 16'(ctrl.mode_request), 16'(keep));
        end
        settle(1);
        chk("hold", 16'(status_hold_default), 16'h0001);
        $display("test_modes done");
    endtask : test_modes

    // Self-clearing pulses, jitter bit, test patterns and loopback.
    task automatic test_ctrl_bits();
        stn.wr(EXT, 16'h0602);
        #1;
        chk("restart", 16'(training_restart), 16'h0001);
        chk("jitter", 16'(ctrl.jitter_test_en), 16'h0001);
        settle(1);
        chk("restart_clr", 16'(training_restart), 16'h0000);
        stn.wr(EXT, 16'h0022);
        #1;
        chk("cable", 16'(cable_test_start), 16'h0001);
        chk("jitter_off", 16'(ctrl.jitter_test_en), 16'h0000);
        settle(1);
        chk("cable_clr", 16'(cable_test_start), 16'h0000);
        for (int t = 0; t < 7; t++) begin
            stn.wr(EXT, 16'(t << 6) | 16'h0002);
            #1;
            chk("test", 16'(ctrl.test_mode), 16'(t));
        end
        // Code 111 is refused while loopback in the same word is stored.
        stn.wr(EXT, 16'h01DA);
        #1;
        chk("loop", 16'(ctrl.loopback_mode), 16'h0003);
        rc(EXT, 16'h619A);
        $display("test_ctrl_bits done");
    endtask : test_ctrl_bits

    // Write gating, configuration fields and the shared pin.
    task automatic test_config();
        @(posedge sys_clk);
        low_power_mode <= 1'b1;
        stn.wr(CF1, 16'h0000);
        rc(CF1, 16'hC910);
        stn.wr(EXT, 16'h0006);
        stn.wr(CF1, 16'h2FED);
        rc(CF1, 16'h2FAC);
        // Each source alone high, then all others high: a wrong mux shows.
        for (int s = 0; s < 4; s++) begin
            stn.wr(CF1, 16'h2F8C | 16'(s << 4));
            status_in <= 4'h1 << s;
            settle(5);
            chk("pin_oe", 16'(shared_pin_oe), 16'h0001);
            chk("wake_en", 16'(wake_input_en), 16'h0000);
            chk("pin_o", 16'(shared_pin_o), 16'h0001);
            @(posedge sys_clk);
            status_in <= ~(4'h1 << s);
            settle(5);
            chk("pin_o_low", 16'(shared_pin_o), 16'h0000);
        end
        stn.wr(CF1, 16'h2FA4);
        settle(5);
        chk("pin_oe_off", 16'(shared_pin_oe), 16'h0000);
        chk("wake_en_on", 16'(wake_input_en), 16'h0001);
        chk("wake", 16'(local_wake), 16'h0001);
        $display("test_config done");
    endtask : test_config

    // Supply policy in Disable mode, link enable and wake request.
    task automatic test_supply_wake();
        @(posedge sys_clk);
        disable_mode <= 1'b1;
        stn.wr(EXT, 16'h0000);
        settle(3);
        chk("supply_off", 16'(supply_control_output), 16'h0000);
        stn.wr(EXT, 16'h8002);
        settle(3);
        chk("supply_on", 16'(supply_control_output), 16'h0001);
        chk("hold_off", 16'(status_hold_default), 16'h0000);
        // Link control is cleared before the wake request is set.
        stn.wr(EXT, 16'h0002);
        stn.wr(EXT, 16'h0003);
        #1;
        chk("wake_tx", 16'(ctrl.wake_request_tx), 16'h0001);
        rc(EXT, 16'h6003);
        $display("test_supply_wake done");
    endtask : test_supply_wake

    // A second reset with the other strap levels; link enable follows.
    task automatic test_restrap();
        @(posedge sys_clk);
        strap_master <= 1'b0;
        strap_autonomous <= 1'b0;
        strap_iface_mode <= 2'h2;
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        settle(4);
        rc(EXT, 16'h0002);
        rc(CF1, 16'h0A10);
        chk("hold_rst", 16'(status_hold_default), 16'h0001);
        $display("test_restrap done");
    endtask : test_restrap

    // Prints the counts and the verdict, then stops the run.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (num_checks > 0 && mismatches == 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    // Main sequence: reset, strap capture, then each scenario.
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        settle(4);
        test_reset();
        test_modes();
        test_ctrl_bits();
        test_config();
        test_supply_wake();
        test_restrap();
        print_verdict();
    end

    // The tests need about 180 cycles; far longer means a hang.
    initial begin
        #200us;
        mismatches++;
        print_verdict();
    end
endmodule : tb_phy_ext_control_config_regs
